// ==== logic/i2c_ctl_pkg.sv ====
// Shared constants and types for the two-wire bus control block.
// Assumes a Wishbone classic slave port with 32-bit data, 16-bit registers.
package i2c_ctl_pkg;
  localparam int ADR_W = 5;
  localparam logic [ADR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADR_W-1:0] OFS_STAT = 5'h04;
  localparam logic [ADR_W-1:0] OFS_BAUD = 5'h08;
  localparam logic [ADR_W-1:0] OFS_MASK = 5'h0c;
  localparam logic [ADR_W-1:0] OFS_ISRC = 5'h10;
  localparam logic [ADR_W-1:0] OFS_TX   = 5'h14;
  localparam logic [ADR_W-1:0] OFS_OWN  = 5'h18;
  localparam logic [ADR_W-1:0] OFS_RX   = 5'h1c;
  // Control register bit positions.
  localparam int CTL_ON    = 15;
  localparam int CTL_TEN   = 10;
  localparam int CTL_STOP  = 2;
  localparam int CTL_START = 0;
  localparam int CTL_LOW_W = 5;
  localparam logic [15:0] CTRL_WMASK = 16'h8405;
  // Status register bit positions.
  localparam int ST_MFLAG = 0;
  localparam int ST_SFLAG = 1;
  localparam int ST_CFLAG = 2;
  localparam int ST_ACKST = 3;
  localparam int ST_WCOL  = 4;
  localparam int ST_BUSY  = 5;
  localparam int ST_RW    = 6;
  // Current source control fields, then mask width, baud floor, ten-bit header and last bit count.
  localparam int ISRC_EN  = 15;
  localparam int SEL_LSB  = 8;
  localparam int SEL_W    = 3;
  localparam int TRIM_W   = 6;
  localparam int NUM_SRC  = 4;
  localparam int MASK_W   = 10;
  localparam logic [15:0] BAUD_MIN = 16'h0002;
  localparam logic [4:0] TEN_HDR = 5'h1e;
  localparam logic [3:0] LAST_BIT = 4'h8;
  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH,
                            M_STOP_LOW, M_STOP_HIGH, M_STOP_END} mst_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_DATA,
                            S_ACK, S_SKIP} slv_t;
  typedef struct packed {
    logic        m;
    logic        s;
    logic        c;
  } evt_t;
endpackage

// ==== logic/sync2.sv ====
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input is a pin level from outside the mclk domain.
module sync2 (
  input  wire logic mclk,    // System clock.
  input  wire logic reset_n, // Asynchronous reset, active low.
  input  wire logic d,       // Asynchronous input level.
  output logic      q        // Synchronised level.
);
  logic meta_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ==== logic/i2c_ctl.sv ====
// Two-wire bus control layer: enable, pin takeover, master and slave
// engines, event flags, baud generator, address mask, current source.
// Assumes Wishbone classic on mclk; bus pins are open drain, resolved
// outside; higher_prio_i comes from logic on mclk.
//
// The Wishbone interface to the registers and the register offsets were decided locally.
module i2c_ctl
  import i2c_ctl_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  input  wire logic              mclk,        // System clock.
  input  wire logic              reset_n,     // Async reset, low.
  input  wire logic              wb_cyc_i,    // Bus cycle.
  input  wire logic              wb_stb_i,    // Bus strobe.
  input  wire logic              wb_we_i,     // Write enable.
  input  wire logic [ADR_W-1:0]  wb_adr_i,    // Byte address.
  input  wire logic [3:0]        wb_sel_i,    // Byte lanes.
  input  wire logic [31:0]       wb_dat_i,    // Write data.
  output logic      [31:0]       wb_dat_o,    // Read data.
  output logic                   wb_ack_o,    // Acknowledge.
  input  wire logic              scl_i,       // Clock line level.
  output logic                   scl_o,       // Clock line drive value.
  output logic                   scl_oe,      // Clock line pulled low.
  input  wire logic              sda_i,       // Data line level.
  output logic                   sda_o,       // Data line drive value.
  output logic                   sda_oe,      // Data line pulled low.
  input  wire logic              higher_prio_i, // Other owner of pins.
  output logic                   pins_owned,  // Module owns pins.
  output logic                   current_out_enable, // Source on.
  output logic [NUM_SRC-1:0]     current_out_pin,    // One-hot pin.
  output logic [TRIM_W-1:0]      current_trim_value  // Trim code.
);
  if (BAUD_W < 2 || BAUD_W > 16) begin : g_chk
    $error("BAUD_W must lie between 2 and 16");
  end

  logic [15:0]        ctrl_r, ctrl_nxt;
  logic [BAUD_W-1:0]  baud_r, baud_nxt;
  logic [MASK_W-1:0]  mask_r, mask_nxt;
  logic [MASK_W-1:0]  own_r, own_nxt;
  logic               isrc_en_r, isrc_en_nxt;
  logic [SEL_W-1:0]   sel_r, sel_nxt;
  logic [TRIM_W-1:0]  trim_r, trim_nxt;
  logic [7:0]         tx_r, tx_nxt;
  logic               tx_go_r, tx_go_nxt;
  logic               mflag_r, mflag_nxt;
  logic               sflag_r, sflag_nxt;
  logic               cflag_r, cflag_nxt;
  logic               wcol_r, wcol_nxt;
  logic [31:0]        dat_r, dat_nxt;
  logic               ack_r, ack_nxt;
  logic               req;
  logic               m_busy;
  logic               on;
  logic [15:0]        wr;
  evt_t               ev;
  logic               start_done, stop_done;

  function automatic logic [15:0] wmerge(input logic [15:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    wmerge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  // Engine state declared early so the register file can read it.
  mst_t               mst_r, mst_nxt;
  slv_t               slv_r, slv_nxt, safter_r, safter_nxt;
  logic               ackst_r, ackst_nxt;
  logic               rw_r, rw_nxt;
  logic [7:0]         rx_r, rx_nxt;

  assign on     = ctrl_r[CTL_ON];
  assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign m_busy = (mst_r != M_IDLE) | ctrl_r[CTL_START] |
                  ctrl_r[CTL_STOP] | tx_go_r;

  always_comb begin
    ctrl_nxt    = ctrl_r;
    baud_nxt    = baud_r;
    mask_nxt    = mask_r;
    own_nxt     = own_r;
    isrc_en_nxt = isrc_en_r;
    sel_nxt     = sel_r;
    trim_nxt    = trim_r;
    tx_nxt      = tx_r;
    tx_go_nxt   = 1'b0;
    ack_nxt     = req;
    dat_nxt     = 32'h0000_0000;
    wr          = 16'h0000;
    mflag_nxt   = mflag_r;
    sflag_nxt   = sflag_r;
    cflag_nxt   = cflag_r;
    wcol_nxt    = wcol_r;
    if (start_done)
      ctrl_nxt[CTL_START] = 1'b0;
    if (stop_done)
      ctrl_nxt[CTL_STOP] = 1'b0;
    if (req && wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          wr = wmerge(ctrl_r, wb_dat_i, wb_sel_i) & CTRL_WMASK;
          if (m_busy)
            wr[CTL_LOW_W-1:0] = ctrl_r[CTL_LOW_W-1:0];
          ctrl_nxt = wr;
        end
        OFS_STAT: begin
          wr = wmerge(16'h0000, wb_dat_i, wb_sel_i);
          mflag_nxt = mflag_r & ~wr[ST_MFLAG];
          sflag_nxt = sflag_r & ~wr[ST_SFLAG];
          cflag_nxt = cflag_r & ~wr[ST_CFLAG];
          wcol_nxt  = wcol_r & ~wr[ST_WCOL];
        end
        OFS_BAUD: begin
          wr = wmerge(16'(baud_r), wb_dat_i, wb_sel_i);
          baud_nxt = wr[BAUD_W-1:0];
        end
        OFS_MASK: begin
          wr = wmerge(16'(mask_r), wb_dat_i, wb_sel_i);
          mask_nxt = wr[MASK_W-1:0];
        end
        OFS_ISRC: begin
          wr = wmerge({isrc_en_r, 4'h0, sel_r, 2'h0, trim_r},
                      wb_dat_i, wb_sel_i);
          isrc_en_nxt = wr[ISRC_EN];
          sel_nxt     = wr[SEL_LSB +: SEL_W];
          trim_nxt    = wr[TRIM_W-1:0];
        end
        OFS_OWN: begin
          wr = wmerge(16'(own_r), wb_dat_i, wb_sel_i);
          own_nxt = wr[MASK_W-1:0];
        end
        OFS_TX: begin
          if (m_busy || !on || !wb_sel_i[0]) begin
            wcol_nxt = 1'b1;
          end else begin
            tx_nxt    = wb_dat_i[7:0];
            tx_go_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL: dat_nxt = {16'h0000, ctrl_r};
        OFS_STAT: begin
          dat_nxt[ST_MFLAG] = mflag_r;
          dat_nxt[ST_SFLAG] = sflag_r;
          dat_nxt[ST_CFLAG] = cflag_r;
          dat_nxt[ST_ACKST] = ackst_r;
          dat_nxt[ST_WCOL]  = wcol_r;
          dat_nxt[ST_BUSY]  = m_busy;
          dat_nxt[ST_RW]    = rw_r;
        end
        OFS_BAUD: dat_nxt = 32'(baud_r);
        OFS_MASK: dat_nxt = 32'(mask_r);
        OFS_ISRC: dat_nxt = {16'h0000, isrc_en_r, 4'h0, sel_r,
                             2'h0, trim_r};
        OFS_TX:   dat_nxt = {24'h000000, tx_r};
        OFS_OWN:  dat_nxt = 32'(own_r);
        OFS_RX:   dat_nxt = {24'h000000, rx_r};
        default:  dat_nxt = 32'h0000_0000;
      endcase
    end
    // Hardware events win over a same-cycle software clear.
    mflag_nxt = mflag_nxt | ev.m;
    sflag_nxt = sflag_nxt | ev.s;
    cflag_nxt = cflag_nxt | ev.c;
    if (!ctrl_nxt[CTL_ON]) begin
      ctrl_nxt[CTL_START] = 1'b0;
      ctrl_nxt[CTL_STOP]  = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r    <= 16'h0000;
      baud_r    <= BAUD_W'(BAUD_MIN);
      mask_r    <= '0;
      own_r     <= '0;
      isrc_en_r <= 1'b0;
      sel_r     <= '0;
      trim_r    <= '0;
      tx_r      <= 8'h00;
      tx_go_r   <= 1'b0;
      mflag_r   <= 1'b0;
      sflag_r   <= 1'b0;
      cflag_r   <= 1'b0;
      wcol_r    <= 1'b0;
      dat_r     <= 32'h0000_0000;
      ack_r     <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      baud_r    <= baud_nxt;
      mask_r    <= mask_nxt;
      own_r     <= own_nxt;
      isrc_en_r <= isrc_en_nxt;
      sel_r     <= sel_nxt;
      trim_r    <= trim_nxt;
      tx_r      <= tx_nxt;
      tx_go_r   <= tx_go_nxt;
      mflag_r   <= mflag_nxt;
      sflag_r   <= sflag_nxt;
      cflag_r   <= cflag_nxt;
      wcol_r    <= wcol_nxt;
      dat_r     <= dat_nxt;
      ack_r     <= ack_nxt;
    end
  end
  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;

  // Pin sampling and bus condition detection.
  logic scl_s, sda_s, scl_q, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det;

  sync2 u_sync_scl (.mclk(mclk), .reset_n(reset_n), .d(scl_i), .q(scl_s));
  sync2 u_sync_sda (.mclk(mclk), .reset_n(reset_n), .d(sda_i), .q(sda_s));

  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  logic [BAUD_W-1:0]  cnt_r, cnt_nxt, reload;
  logic [3:0]         bitn_r, bitn_nxt, sbit_r, sbit_nxt;
  logic [7:0]         shift_r, shift_nxt, sshift_r, sshift_nxt;
  logic               mscl_r, mscl_nxt, msda_r, msda_nxt;
  logic               ssda_r, ssda_nxt;
  logic               own_oe_r, own_oe_nxt;
  logic               cur_en_r;
  logic [NUM_SRC-1:0] cur_pin_r, cur_pin_nxt;
  logic               bz, match;

  // Values below two are not served; they run as two.
  assign reload = (baud_r < BAUD_W'(BAUD_MIN)) ?
                  BAUD_W'(BAUD_MIN) : baud_r;
  assign bz = (cnt_r == '0);

  always_comb begin
    cnt_nxt    = bz ? cnt_r : cnt_r - 1'b1;
    mst_nxt    = mst_r;
    bitn_nxt   = bitn_r;
    shift_nxt  = shift_r;
    mscl_nxt   = mscl_r;
    msda_nxt   = msda_r;
    ackst_nxt  = ackst_r;
    slv_nxt    = slv_r;
    safter_nxt = safter_r;
    sbit_nxt   = sbit_r;
    sshift_nxt = sshift_r;
    ssda_nxt   = ssda_r;
    rw_nxt     = rw_r;
    rx_nxt     = rx_r;
    ev         = '0;
    start_done = 1'b0;
    stop_done  = 1'b0;
    match      = 1'b0;
    // Master engine.
    case (mst_r)
      M_IDLE: begin
        if (ctrl_r[CTL_START]) begin
          if (!scl_s || !sda_s) begin
            ev.c = 1'b1;
            ev.m = 1'b1;
            start_done = 1'b1;
          end else begin
            msda_nxt = 1'b1;
            cnt_nxt  = reload;
            mst_nxt  = M_START;
          end
        end else if (ctrl_r[CTL_STOP]) begin
          msda_nxt = 1'b1;
          mscl_nxt = 1'b1;
          cnt_nxt  = reload;
          mst_nxt  = M_STOP_LOW;
        end else if (tx_go_r) begin
          shift_nxt = tx_r;
          msda_nxt  = ~tx_r[7];
          mscl_nxt  = 1'b1;
          bitn_nxt  = 4'h0;
          cnt_nxt   = reload;
          mst_nxt   = M_LOW;
        end
      end
      M_START: if (bz) begin
        mscl_nxt   = 1'b1;
        start_done = 1'b1;
        ev.m       = 1'b1;
        mst_nxt    = M_IDLE;
      end
      M_LOW: if (bz) begin
        mscl_nxt = 1'b0;
        cnt_nxt  = reload;
        mst_nxt  = M_HIGH;
      end
      M_HIGH: begin
        if (!scl_s) begin
          cnt_nxt = reload;
        end else if (bz) begin
          if (bitn_r == LAST_BIT) begin
            ackst_nxt = sda_s;
          end
          if (bitn_r != LAST_BIT && !msda_r && !sda_s) begin
            ev.c     = 1'b1;
            ev.m     = 1'b1;
            msda_nxt = 1'b0;
            mst_nxt  = M_IDLE;
          end else if (bitn_r == LAST_BIT) begin
            mscl_nxt = 1'b1;
            ev.m     = 1'b1;
            mst_nxt  = M_IDLE;
          end else begin
            mscl_nxt  = 1'b1;
            bitn_nxt  = bitn_r + 4'h1;
            shift_nxt = {shift_r[6:0], 1'b0};
            msda_nxt  = (bitn_r == LAST_BIT - 4'h1) ? 1'b0 : ~shift_r[6];
            cnt_nxt   = reload;
            mst_nxt   = M_LOW;
          end
        end
      end
      M_STOP_LOW: if (bz) begin
        mscl_nxt = 1'b0;
        cnt_nxt  = reload;
        mst_nxt  = M_STOP_HIGH;
      end
      M_STOP_HIGH: begin
        if (!scl_s) begin
          cnt_nxt = reload;
        end else if (bz) begin
          msda_nxt = 1'b0;
          cnt_nxt  = reload;
          mst_nxt  = M_STOP_END;
        end
      end
      M_STOP_END: if (bz) begin
        ev.m      = 1'b1;
        ev.c      = ~sda_s;
        stop_done = 1'b1;
        mst_nxt   = M_IDLE;
      end
      default: mst_nxt = M_IDLE;
    endcase
    // Slave engine runs beside the master on the same samples.
    if (scl_rise && slv_r inside {S_ADDR, S_ADDR2, S_DATA}) begin
      sshift_nxt = {sshift_r[6:0], sda_s};
      sbit_nxt   = sbit_r + 4'h1;
    end
    if (scl_fall && sbit_r == LAST_BIT) begin
      sbit_nxt = 4'h0;
      case (slv_r)
        S_ADDR: begin
          if (ctrl_r[CTL_TEN]) begin
            match = sshift_r[7:3] == TEN_HDR && !sshift_r[0] &&
                    ((sshift_r[2:1] ^ own_r[9:8]) & ~mask_r[9:8])
                    == 2'b00;
            safter_nxt = S_ADDR2;
          end else begin
            match = ((sshift_r[7:1] ^ own_r[6:0]) & ~mask_r[6:0])
                    == 7'h00 || sshift_r[7:1] == 7'h00;
            rw_nxt     = sshift_r[0];
            ev.s       = match;
            safter_nxt = sshift_r[0] ? S_SKIP : S_DATA;
          end
        end
        S_ADDR2: begin
          match = ((sshift_r ^ own_r[7:0]) & ~mask_r[7:0])
                  == 8'h00;
          rw_nxt     = 1'b0;
          ev.s       = match;
          safter_nxt = S_DATA;
        end
        S_DATA: begin
          match  = 1'b1;
          rx_nxt = sshift_r;
          ev.s   = 1'b1;
        end
        default: match = 1'b0;
      endcase
      if (slv_r inside {S_ADDR, S_ADDR2, S_DATA}) begin
        ssda_nxt = match;
        slv_nxt  = match ? S_ACK : S_SKIP;
      end
    end else if (scl_fall && slv_r == S_ACK) begin
      ssda_nxt = 1'b0;
      slv_nxt  = safter_r;
    end
    if (start_det) begin
      slv_nxt  = S_ADDR;
      sbit_nxt = 4'h0;
      ssda_nxt = 1'b0;
      ev.s     = 1'b1;
    end else if (stop_det) begin
      slv_nxt  = S_IDLE;
      ssda_nxt = 1'b0;
      ev.s     = 1'b1;
    end
    own_oe_nxt = on & ~higher_prio_i;
    if (!on) begin
      mst_nxt  = M_IDLE;
      slv_nxt  = S_IDLE;
      mscl_nxt = 1'b0;
      msda_nxt = 1'b0;
      ssda_nxt = 1'b0;
      ev       = '0;
    end
    case (sel_r)
      3'h1, 3'h2, 3'h3, 3'h4:
        cur_pin_nxt = NUM_SRC'(1) << (sel_r - 3'h1);
      default: cur_pin_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r     <= '0;
      mst_r     <= M_IDLE;
      bitn_r    <= 4'h0;
      shift_r   <= 8'h00;
      mscl_r    <= 1'b0;
      msda_r    <= 1'b0;
      ackst_r   <= 1'b0;
      slv_r     <= S_IDLE;
      safter_r  <= S_IDLE;
      sbit_r    <= 4'h0;
      sshift_r  <= 8'h00;
      ssda_r    <= 1'b0;
      rw_r      <= 1'b0;
      rx_r      <= 8'h00;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      own_oe_r  <= 1'b0;
      scl_oe    <= 1'b0;
      sda_oe    <= 1'b0;
      cur_en_r  <= 1'b0;
      cur_pin_r <= '0;
    end else begin
      cnt_r     <= cnt_nxt;
      mst_r     <= mst_nxt;
      bitn_r    <= bitn_nxt;
      shift_r   <= shift_nxt;
      mscl_r    <= mscl_nxt;
      msda_r    <= msda_nxt;
      ackst_r   <= ackst_nxt;
      slv_r     <= slv_nxt;
      safter_r  <= safter_nxt;
      sbit_r    <= sbit_nxt;
      sshift_r  <= sshift_nxt;
      ssda_r    <= ssda_nxt;
      rw_r      <= rw_nxt;
      rx_r      <= rx_nxt;
      scl_q     <= scl_s;
      sda_q     <= sda_s;
      own_oe_r  <= own_oe_nxt;
      scl_oe    <= own_oe_nxt & mscl_nxt;
      sda_oe    <= own_oe_nxt & (msda_nxt | ssda_nxt);
      cur_en_r  <= isrc_en_r;
      cur_pin_r <= cur_pin_nxt;
    end
  end
  assign scl_o              = 1'b0;
  assign sda_o              = 1'b0;
  assign pins_owned         = own_oe_r;
  assign current_out_enable = cur_en_r;
  assign current_out_pin    = cur_pin_r;
  assign current_trim_value = trim_r;

  property p_mask_hi;
    @(posedge mclk) disable iff (!reset_n)
    ack_r && !$past(wb_we_i) && $past(wb_adr_i) == OFS_MASK
    |-> dat_r[15:10] == 6'h00;
  endproperty
  a_mask_hi: assert property (p_mask_hi)
    else $error("mask upper bits not zero");
  property p_src_en;
    @(posedge mclk) disable iff (!reset_n)
    ##1 current_out_enable == $past(isrc_en_r);
  endproperty
  a_src_en: assert property (p_src_en)
    else $error("current enable does not follow register");
  property p_src_pin;
    @(posedge mclk) disable iff (!reset_n)
    (sel_r == 3'h0 || sel_r > 3'h4) |=> current_out_pin == '0;
  endproperty
  a_src_pin: assert property (p_src_pin)
    else $error("pin selected for idle or reserved code");
  property p_off_release;
    @(posedge mclk) disable iff (!reset_n)
    !on |=> !scl_oe && !sda_oe;
  endproperty
  a_off_release: assert property (p_off_release)
    else $error("lines driven while disabled");
  property p_owned;
    @(posedge mclk) disable iff (!reset_n)
    ##1 pins_owned == $past(on && !higher_prio_i);
  endproperty
  a_owned: assert property (p_owned)
    else $error("pin ownership wrong");
  property p_start_flag;
    @(posedge mclk) disable iff (!reset_n)
    $fell(ctrl_r[CTL_START]) && on |-> mflag_r;
  endproperty
  a_start_flag: assert property (p_start_flag)
    else $error("start cleared without master flag");
  property p_byte_flag;
    @(posedge mclk) disable iff (!reset_n)
    on && mst_r == M_HIGH && mst_nxt == M_IDLE |=> mflag_r;
  endproperty
  a_byte_flag: assert property (p_byte_flag)
    else $error("byte end without master flag");
  property p_coll;
    @(posedge mclk) disable iff (!reset_n)
    ev.c |=> cflag_r && mflag_r;
  endproperty
  a_coll: assert property (p_coll)
    else $error("collision not flagged");
  property p_count;
    @(posedge mclk) disable iff (!reset_n)
    !bz && mst_r == M_LOW ##1 mst_r == M_LOW |-> cnt_r == $past(cnt_r) - 1'b1;
  endproperty
  a_count: assert property (p_count)
    else $error("baud counter did not step down");
endmodule

// ==== tb/bus_partner.sv ====
// Far side of the two-wire bus: pull-ups, an acking receiver, a sender.
// Assumes the block pulls a line low while its enable is high.
module bus_partner (
  input  wire logic scl_oe, // Block pulls clock low.
  input  wire logic sda_oe, // Block pulls data low.
  output logic      scl_i,  // Resolved clock line.
  output logic      sda_i   // Resolved data line.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_m = 1'b1;
  logic       sda_m = 1'b1;
  logic       ack_m = 1'b1;
  logic       ack_seen;
  logic [7:0] rx_r;
  int         nf = 0;
  // Both lines have pull-ups, so a released line reads high.
  assign scl_i = ~scl_oe & scl_m;
  assign sda_i = ~sda_oe & sda_m & ack_m;
  always @(negedge sda_i) if (scl_i) nf = 0;
  always @(negedge scl_i) begin
    nf++;
    ack_m = (nf != 9);
  end
  always @(posedge scl_i) if (nf >= 1 && nf <= 8) rx_r = {rx_r[6:0], sda_i};
  // Sends start, one byte, the acknowledge clock and stop at 160 ns.
  task send(input logic [7:0] b);
    sda_m = 1'b0;
    #80 scl_m = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_m = b[i];
      #80 scl_m = 1'b1;
      #80 scl_m = 1'b0;
    end
    sda_m = 1'b1;
    #80 scl_m = 1'b1;
    #40 ack_seen = sda_oe;
    #40 scl_m = 1'b0;
    #80 sda_m = 1'b0;
    #80 scl_m = 1'b1;
    #80 sda_m = 1'b1;
    #160;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the two-wire bus control block.
// Assumes the bus partner model resolves both lines.
module tb;
  import i2c_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             mclk;
  logic             reset_n = 1'b0;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, hp = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0]      wdat = '0, rdat, v, seed = 32'h28;
  logic             ack, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  logic             owned, cen;
  logic [3:0]       cpin;
  logic [5:0]       trim;
  logic [15:0]      q, st, d;
  int               n_fail = 0, n_tests = 0;
  i2c_ctl dut (.mclk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i, .scl_o, .scl_oe, .sda_i,
    .sda_o, .sda_oe, .higher_prio_i(hp), .pins_owned(owned),
    .current_out_enable(cen), .current_out_pin(cpin),
    .current_trim_value(trim));
  bus_partner link (.scl_oe, .sda_oe, .scl_i, .sda_i);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reload for a bus rate in kHz, 120 ns of line delay, 200 MHz clock.
  function automatic logic [15:0] brg_of(int khz);
    return 16'((1_000_000 / khz - 120) * 200 / 1000 - 2);
  endfunction
  function automatic logic [3:0] pin_of(logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h4) ? 4'h1 << (c - 3'h1) : 4'h0;
  endfunction
  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] x);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, x};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (ack !== 1'b1) begin
      n_fail++;
      $display("unexpected ack expected 1 seen %b", ack);
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_flag(input int b);
    for (int i = 0; i < 400; i++) begin
      wb(1'b0, OFS_STAT, 16'h0000);
      if (q[b] === 1'b1) break;
    end
    st = q;
    chk("flag", 16'h0001, {15'h0, st[b]});
    wb(1'b1, OFS_STAT, 16'h0001 << b);
  endtask
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    wb(1'b0, OFS_MASK, 16'h0000);
    chk("mask_reset", 16'h0000, q);
    v = xs();
    wb(1'b1, OFS_MASK, v[15:0]);
    wb(1'b0, OFS_MASK, 16'h0000);
    chk("mask", {6'h00, v[9:0]}, q);
    for (int c = 0; c < 8; c++) begin
      v = xs();
      d = {c[0], 4'h0, c[2:0], 2'b00, v[5:0]};
      wb(1'b1, OFS_ISRC, d);
      wb(1'b0, OFS_ISRC, 16'h0000);
      chk("isrc", d, q);
      chk("pin", {12'h0, pin_of(c[2:0])}, {12'h0, cpin});
      chk("cen", {15'h0, c[0]}, {15'h0, cen});
      chk("trim", {10'h0, v[5:0]}, {10'h0, trim});
    end
    wb(1'b1, OFS_OWN, 16'h002a);
    wb(1'b1, OFS_BAUD, brg_of(400));
    wb(1'b0, OFS_BAUD, 16'h0000);
    chk("baud", brg_of(400), q);
    wb(1'b1, OFS_BAUD, BAUD_MIN);
    wb(1'b1, OFS_CTRL, 16'h8000);
    @(posedge mclk);
    chk("owned", 16'h0001, {15'h0, owned});
    chk("oe", 16'h0000, {14'h0, scl_oe, sda_oe});
    hp <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("preempt", 16'h0000, {15'h0, owned});
    hp <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, OFS_CTRL, m[1] ? 16'h8400 : 16'h8000);
      wb(1'b1, OFS_MASK, m[1] ? 16'(m[0]) << 8 : 16'(m[0]));
      link.send(m[1] ? 8'hf2 : {7'h2b, 1'b0});
      chk("slave_ack", 16'(m[0]), {15'h0, link.ack_seen});
      wait_flag(ST_SFLAG);
    end
    // A start asked for while the data line is held low must collide.
    link.sda_m <= 1'b0;
    wb(1'b1, OFS_CTRL, 16'h8001);
    wait_flag(ST_CFLAG);
    wait_flag(ST_MFLAG);
    link.sda_m <= 1'b1;
    repeat (4) @(posedge mclk);
    wb(1'b1, OFS_CTRL, 16'h8001);
    wait_flag(ST_MFLAG);
    wb(1'b0, OFS_CTRL, 16'h0000);
    chk("start_bit", 16'h0000, {15'h0, q[CTL_START]});
    v = xs();
    wb(1'b1, OFS_TX, {8'h00, v[7:0]});
    wait_flag(ST_MFLAG);
    chk("tx", {8'h00, v[7:0]}, {8'h00, link.rx_r});
    chk("ackstat", 16'h0000, {15'h0, st[ST_ACKST]});
    wb(1'b1, OFS_CTRL, 16'h8004);
    wait_flag(ST_MFLAG);
    stop_test();
  end
endmodule
